// ==== verilog/fcts_pkg.sv ====
// Constants, command codes and state encodings for the flash command timing sequencer.
// Assumes a single bus clock domain; all counts are in bus or operating clock cycles.
package fcts_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int CMD_W   = 8;
   localparam int DIV_W   = 7;
   localparam int CNT_W   = 18;
   localparam int PHRASE_W = 16;

   // ************************************************************
   // Command codes
   // ************************************************************
   localparam logic [CMD_W-1:0] CMD_VERIFY_ALL    = 8'h01;
   localparam logic [CMD_W-1:0] CMD_VERIFY_BLOCK  = 8'h02;
   localparam logic [CMD_W-1:0] CMD_VERIFY_SECT   = 8'h03;
   localparam logic [CMD_W-1:0] CMD_READ_ONCE     = 8'h04;
   localparam logic [CMD_W-1:0] CMD_PROG_PHRASE   = 8'h06;
   localparam logic [CMD_W-1:0] CMD_PROG_ONCE     = 8'h07;
   localparam logic [CMD_W-1:0] CMD_ERASE_ALL     = 8'h08;
   localparam logic [CMD_W-1:0] CMD_ERASE_PBLOCK  = 8'h09;
   localparam logic [CMD_W-1:0] CMD_ERASE_SECTOR  = 8'h0a;
   localparam logic [CMD_W-1:0] CMD_UNSECURE      = 8'h0b;
   localparam logic [CMD_W-1:0] CMD_BACKDOOR_KEY  = 8'h0c;
   localparam logic [CMD_W-1:0] CMD_USER_MARGIN   = 8'h0d;
   localparam logic [CMD_W-1:0] CMD_FIELD_MARGIN  = 8'h0e;

   // ************************************************************
   // Cycle counts (bus cycles unless named _OP)
   // ************************************************************
   localparam int VERIFY_ALL_TOTAL    = 35500;
   localparam int VERIFY_PBLOCK_TOTAL = 33500;
   localparam int VERIFY_DBLOCK_TOTAL = 2800;
   localparam int VERIFY_SETUP        = 500;
   localparam int SECT_SETUP          = 450;
   localparam int READ_ONCE_BUS       = 400;
   localparam int PROG_PHRASE_OP      = 164;
   localparam int PROG_PHRASE_BUS     = 2500;
   localparam int PROG_ONCE_OP        = 164;
   localparam int PROG_ONCE_BUS       = 2150;
   localparam int MASS_ERASE_OP       = 100100;
   localparam int ERASE_ALL_BUS       = 70000;
   localparam int ERASE_PBLOCK_BUS    = 67000;
   localparam int SECTOR_ERASE_OP     = 20020;
   localparam int SECTOR_ERASE_BUS    = 1400;
   localparam int UNSECURE_BUS        = 70000;
   localparam int BACKDOOR_BUS        = 400;
   localparam int MARGIN_BUS          = 350;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [DIV_W-1:0] DIV_CNT_RESET = 7'h00;
   localparam logic [CNT_W-1:0] CNT_RESET     = 18'h00000;

   // ************************************************************
   // State machine
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_OP    = 3'b001,
      ST_BUS   = 3'b010,
      ST_SETUP = 3'b011,
      ST_SCAN  = 3'b100
   } fcts_state_type;

endpackage

// ==== verilog/fcts_clkdiv.sv ====
// Operating clock tick generator: one CLK-wide tick every (divider + 1) bus cycles.
// Assumes the divider value is static while a command runs.
`timescale 1ns/1ns
module fcts_clkdiv (
   input  wire logic                       CLK,
   input  wire logic                       NRST,
   input  wire logic [fcts_pkg::DIV_W-1:0] DIVIDER,
   output logic                            TICK
);
   import fcts_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] count;
      logic             tick;
   } fcts_div_type;

   fcts_div_type r;
   fcts_div_type next_r;

   // divide bus clock
   // The band of the resulting frequency is not checked here; software owns that.
   always_comb begin
      next_r = r;
      next_r.tick = 1'b0;
      if (r.count >= DIVIDER) begin
         next_r.count = DIV_CNT_RESET;
         next_r.tick  = 1'b1;
      end else begin
         next_r.count = r.count + 7'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign TICK = r.tick;

endmodule

// ==== verilog/fcts_sequencer.sv ====
// Flash command timing sequencer: runs each flash command for its documented
// number of operating-clock and bus-clock cycles and reports busy and done.
// Assumes CMD_LAUNCH, FLASH_COMMAND_CODE and NON_BLANK come from logic on CLK.
//
// Overview of operation
// - Operating clock divided from bus clock
// - No frequency check, never block commands
// - 0x01 blank-checks all, stops on nonblank
// - 0x02 blank-checks one program or data block
// - 0x03 section verify, 450 plus phrases
// - 0x04 read once within 400 cycles
// - 0x06 phrase program, 164 op plus 2500
// - 0x07 program once, 164 op plus 2150
// - 0x08 erase all, 100100 op plus 70000
// - 0x09 erase program block, plus 67000
// - 0x0A sector erase, 20020 op plus 1400
// - 0x0B erase all then unsecure
// - 0x0C backdoor key check within 400
// - 0x0D user margin within 350 cycles
// - 0x0E field margin within 350 cycles
`timescale 1ns/1ns
module fcts_sequencer #(
   parameter int P_VERIFY_ALL_TOTAL    = fcts_pkg::VERIFY_ALL_TOTAL,
   parameter int P_VERIFY_PBLOCK_TOTAL = fcts_pkg::VERIFY_PBLOCK_TOTAL,
   parameter int P_MASS_ERASE_OP       = fcts_pkg::MASS_ERASE_OP,
   parameter int P_ERASE_ALL_BUS       = fcts_pkg::ERASE_ALL_BUS,
   parameter int P_ERASE_PBLOCK_BUS    = fcts_pkg::ERASE_PBLOCK_BUS,
   parameter int P_SECTOR_ERASE_OP     = fcts_pkg::SECTOR_ERASE_OP,
   parameter int P_UNSECURE_BUS        = fcts_pkg::UNSECURE_BUS
) (
   input  wire logic                          CLK,
   input  wire logic                          NRST,
   input  wire logic                          CMD_LAUNCH,
   input  wire logic [fcts_pkg::CMD_W-1:0]    FLASH_COMMAND_CODE,
   input  wire logic [fcts_pkg::DIV_W-1:0]    NVM_CLOCK_DIVIDER,
   input  wire logic                          DATA_BLOCK_SEL,
   input  wire logic [fcts_pkg::PHRASE_W-1:0] PHRASE_COUNT,
   input  wire logic                          NON_BLANK,
   input  wire logic                          DONE_CLEAR,
   output logic                               BUSY,
   output logic                               CMD_DONE,
   output logic                               VERIFY_FAIL,
   output logic                               CMD_ILLEGAL
);
   import fcts_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      fcts_state_type   state;
      logic [CNT_W-1:0] op_left;
      logic [CNT_W-1:0] bus_left;
      logic [CNT_W-1:0] scan_left;
      logic             busy;
      logic             done;
      logic             fail;
      logic             illegal;
   } fcts_seq_type;

   fcts_seq_type r;
   fcts_seq_type next_r;
   logic         op_tick;

   fcts_clkdiv u_clkdiv (
      .CLK     (CLK),
      .NRST    (NRST),
      .DIVIDER (NVM_CLOCK_DIVIDER),
      .TICK    (op_tick)
   );

   // ************************************************************
   // Sequencing
   // ************************************************************
   // Bus counts are loaded as the number of cycles spent in ST_BUS, so a
   // command with only a bus part is busy for exactly that many cycles.
   always_comb begin
      next_r = r;
      // Clearing loses to a completion in the same cycle.
      if (DONE_CLEAR) begin
         next_r.done    = 1'b0;
         next_r.fail    = 1'b0;
         next_r.illegal = 1'b0;
      end
      unique case (r.state)
         ST_IDLE: begin
            // A launch while busy cannot reach here; it is ignored by design.
            if (CMD_LAUNCH) begin
               next_r.busy      = 1'b1;
               next_r.done      = 1'b0;
               next_r.fail      = 1'b0;
               next_r.illegal   = 1'b0;
               next_r.op_left   = CNT_RESET;
               next_r.bus_left  = CNT_RESET;
               next_r.scan_left = CNT_RESET;
               next_r.state     = ST_BUS;
               case (FLASH_COMMAND_CODE)
                  CMD_VERIFY_ALL: begin
                     next_r.bus_left  = CNT_W'(VERIFY_SETUP);
                     next_r.scan_left = CNT_W'(P_VERIFY_ALL_TOTAL - VERIFY_SETUP);
                     next_r.state     = ST_SETUP;
                  end
                  CMD_VERIFY_BLOCK: begin
                     next_r.bus_left  = CNT_W'(VERIFY_SETUP);
                     next_r.scan_left = DATA_BLOCK_SEL ?
                                        CNT_W'(VERIFY_DBLOCK_TOTAL - VERIFY_SETUP) :
                                        CNT_W'(P_VERIFY_PBLOCK_TOTAL - VERIFY_SETUP);
                     next_r.state     = ST_SETUP;
                  end
                  CMD_VERIFY_SECT: begin
                     next_r.bus_left  = CNT_W'(SECT_SETUP);
                     next_r.scan_left = CNT_W'(PHRASE_COUNT);
                     next_r.state     = ST_SETUP;
                  end
                  CMD_READ_ONCE: next_r.bus_left = CNT_W'(READ_ONCE_BUS);
                  CMD_PROG_PHRASE: begin
                     next_r.op_left  = CNT_W'(PROG_PHRASE_OP);
                     next_r.bus_left = CNT_W'(PROG_PHRASE_BUS);
                     next_r.state    = ST_OP;
                  end
                  CMD_PROG_ONCE: begin
                     next_r.op_left  = CNT_W'(PROG_ONCE_OP);
                     next_r.bus_left = CNT_W'(PROG_ONCE_BUS);
                     next_r.state    = ST_OP;
                  end
                  CMD_ERASE_ALL: begin
                     next_r.op_left  = CNT_W'(P_MASS_ERASE_OP);
                     next_r.bus_left = CNT_W'(P_ERASE_ALL_BUS);
                     next_r.state    = ST_OP;
                  end
                  CMD_ERASE_PBLOCK: begin
                     next_r.op_left  = CNT_W'(P_MASS_ERASE_OP);
                     next_r.bus_left = CNT_W'(P_ERASE_PBLOCK_BUS);
                     next_r.state    = ST_OP;
                  end
                  CMD_ERASE_SECTOR: begin
                     next_r.op_left  = CNT_W'(P_SECTOR_ERASE_OP);
                     next_r.bus_left = CNT_W'(SECTOR_ERASE_BUS);
                     next_r.state    = ST_OP;
                  end
                  CMD_UNSECURE: begin
                     next_r.op_left  = CNT_W'(P_MASS_ERASE_OP);
                     next_r.bus_left = CNT_W'(P_UNSECURE_BUS);
                     next_r.state    = ST_OP;
                  end
                  CMD_BACKDOOR_KEY: next_r.bus_left = CNT_W'(BACKDOOR_BUS);
                  CMD_USER_MARGIN: next_r.bus_left = CNT_W'(MARGIN_BUS);
                  CMD_FIELD_MARGIN: next_r.bus_left = CNT_W'(MARGIN_BUS);
                  default: begin
                     // Unknown codes finish at once with the illegal flag.
                     next_r.busy    = 1'b0;
                     next_r.done    = 1'b1;
                     next_r.illegal = 1'b1;
                     next_r.state   = ST_IDLE;
                  end
               endcase
            end
         end
         ST_OP: begin
            // Operating-clock part; its real length follows the divider setting.
            if (op_tick) begin
               next_r.op_left = r.op_left - 18'h00001;
               if (r.op_left <= 18'h00001) begin
                  next_r.state = ST_BUS;
               end
            end
         end
         ST_BUS: begin
            next_r.bus_left = r.bus_left - 18'h00001;
            if (r.bus_left <= 18'h00001) begin
               next_r.busy  = 1'b0;
               next_r.done  = 1'b1;
               next_r.state = ST_IDLE;
            end
         end
         ST_SETUP: begin
            next_r.bus_left = r.bus_left - 18'h00001;
            if (r.bus_left <= 18'h00001) begin
               if (r.scan_left == CNT_RESET) begin
                  next_r.busy  = 1'b0;
                  next_r.done  = 1'b1;
                  next_r.state = ST_IDLE;
               end else begin
                  next_r.state = ST_SCAN;
               end
            end
         end
         ST_SCAN: begin
            // stop at first nonblank
            // One phrase per bus cycle; a non-blank phrase ends the scan early.
            next_r.scan_left = r.scan_left - 18'h00001;
            if (NON_BLANK || r.scan_left <= 18'h00001) begin
               next_r.fail  = NON_BLANK;
               next_r.busy  = 1'b0;
               next_r.done  = 1'b1;
               next_r.state = ST_IDLE;
            end
         end
         default: begin
            next_r.busy  = 1'b0;
            next_r.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         r <= '{state: ST_IDLE, op_left: CNT_RESET, bus_left: CNT_RESET,
                scan_left: CNT_RESET, busy: 1'b0, done: 1'b0, fail: 1'b0,
                illegal: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign BUSY        = r.busy;
   assign CMD_DONE    = r.done;
   assign VERIFY_FAIL = r.fail;
   assign CMD_ILLEGAL = r.illegal;

endmodule

// ==== dv/fcts_sva.sv ====
// Timing checker for the flash command timing sequencer.
// Assumes it is bound to fcts_sequencer and sees only its ports.
`timescale 1ns/1ns
module fcts_sva
   import fcts_pkg::*;
(
   input wire logic                          CLK,
   input wire logic                          NRST,
   input wire logic                          CMD_LAUNCH,
   input wire logic [fcts_pkg::CMD_W-1:0]    FLASH_COMMAND_CODE,
   input wire logic [fcts_pkg::PHRASE_W-1:0] PHRASE_COUNT,
   input wire logic                          DONE_CLEAR,
   input wire logic                          BUSY,
   input wire logic                          CMD_DONE,
   input wire logic                          VERIFY_FAIL,
   input wire logic                          CMD_ILLEGAL
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // A launch only counts while idle, since a busy sequencer ignores it.
   wire go = CMD_LAUNCH && !BUSY;
   // Long commands are timed by counting busy cycles, since delays that long are
   // too costly for the tools to unroll.
   logic [CNT_W-1:0]    busy_len;
   logic [CMD_W-1:0]    run_code;
   logic [PHRASE_W-1:0] run_phr;
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         busy_len <= CNT_RESET;
         run_code <= 8'h00;
         run_phr  <= 16'h0000;
      end else if (go) begin
         busy_len <= CNT_RESET;
         run_code <= FLASH_COMMAND_CODE;
         run_phr  <= PHRASE_COUNT;
      end else if (BUSY) begin
         busy_len <= busy_len + 18'h00001;
      end
   end
   a_launch_busy: assert property (
      go && FLASH_COMMAND_CODE inside {[8'h01:8'h04], [8'h06:8'h0e]} |=> BUSY)
      else $error("Busy missing after launch.");
   a_margin_len: assert property (
      $fell(BUSY) && run_code inside {8'h0d, 8'h0e} |-> busy_len == 18'h0015e && CMD_DONE)
      else $error("Margin command length wrong.");
   a_once_key_len: assert property (
      $fell(BUSY) && run_code inside {8'h04, 8'h0c} |-> busy_len == 18'h00190 && CMD_DONE)
      else $error("Read or key command length wrong.");
   a_sect_len: assert property (
      $fell(BUSY) && run_code == 8'h03 && !VERIFY_FAIL
      |-> busy_len == 18'h001c2 + {2'b00, run_phr} && CMD_DONE)
      else $error("Section verify length wrong.");
   a_bad_code: assert property (
      go && FLASH_COMMAND_CODE == 8'h05 |=> CMD_ILLEGAL && CMD_DONE && !BUSY)
      else $error("Unknown code not flagged.");
   a_end_done: assert property (
      $fell(BUSY) |-> CMD_DONE && !CMD_ILLEGAL) else $error("Busy ended without done.");
   a_fail_ends: assert property (
      $rose(VERIFY_FAIL) |-> $fell(BUSY) && CMD_DONE) else $error("Fail flag off its end.");
   a_clear_flags: assert property (
      DONE_CLEAR && !BUSY && !CMD_LAUNCH |=> !CMD_DONE && !CMD_ILLEGAL && !VERIFY_FAIL)
      else $error("Flags not cleared.");
endmodule
bind fcts_sequencer fcts_sva i_fcts_sva (.CLK, .NRST, .CMD_LAUNCH, .FLASH_COMMAND_CODE,
   .PHRASE_COUNT, .DONE_CLEAR, .BUSY, .CMD_DONE, .VERIFY_FAIL, .CMD_ILLEGAL);

// ==== dv/fcts_sequencer_tb_top.sv ====
// Self-checking bench for the flash command timing sequencer.
// Assumes shortened long counts set at the instance; one clock domain.
`timescale 1ns/1ns
module fcts_sequencer_tb_top;
   import fcts_pkg::*;
   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                go = 1'b0;
   logic [CMD_W-1:0]    code = 8'h00;
   logic [DIV_W-1:0]    div = 7'h03;
   logic                sel = 1'b0;
   logic [PHRASE_W-1:0] pc = 16'h0000;
   logic                nb = 1'b0;
   logic                clr = 1'b0;
   logic                busy, done, vfail, illeg;
   int                  err_total = 0;
   int                  total_checks = 0;
   int                  n;
   always #4 clk = ~clk;
   fcts_sequencer #(.P_VERIFY_ALL_TOTAL(600), .P_MASS_ERASE_OP(20),
      .P_ERASE_ALL_BUS(50), .P_ERASE_PBLOCK_BUS(50),
      .P_UNSECURE_BUS(50)) i_fcts_sequencer (.CLK(clk), .NRST(nrst), .CMD_LAUNCH(go),
      .FLASH_COMMAND_CODE(code), .NVM_CLOCK_DIVIDER(div), .DATA_BLOCK_SEL(sel),
      .PHRASE_COUNT(pc), .NON_BLANK(nb), .DONE_CLEAR(clr), .BUSY(busy), .CMD_DONE(done),
      .VERIFY_FAIL(vfail), .CMD_ILLEGAL(illeg));
   task automatic close_out();
      if (err_total == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   // Launch at the next edge; n counts edges until done, so n is length plus one.
   task automatic run(input logic [7:0] c, input int lim);
      @(negedge clk);
      code = c;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic t_bus();
      logic [7:0] c [4] = '{8'h04, 8'h0c, 8'h0d, 8'h0e};
      int t [4] = '{400, 400, 350, 350};
      for (int i = 0; i < 4; i++) begin
         run(c[i], 1000);
         check(n, t[i] + 1);
         check({busy, illeg}, 2'b00);
      end
   endtask
   task automatic t_blank();
      run(8'h01, 4000);
      check(n, 601);
      sel = 1'b1;
      run(8'h02, 4000);
      check(n, 2801);
      sel = 1'b0;
      run(8'h02, 40000);
      check(n, VERIFY_PBLOCK_TOTAL + 1);
      check(vfail, 1'b0);
      nb = 1'b1;
      run(8'h01, 4000);
      nb = 1'b0;
      check(n, VERIFY_SETUP + 2);
      check(vfail, 1'b1);
      pc = 16'h0000;
      run(8'h03, 1000);
      check(n, 451);
      pc = 16'h0007;
      run(8'h03, 1000);
      check(n, 458);
   endtask
   // The divider phase runs free, so the operating part may lose up to one tick.
   task automatic t_op();
      logic [7:0] c [7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h08};
      int op [7] = '{164, 164, 20, 20, SECTOR_ERASE_OP, 20, 20};
      int bus [7] = '{2500, 2150, 50, 50, 1400, 50, 50};
      int d [7] = '{3, 0, 1, 2, 0, 1, 127};
      for (int i = 0; i < 7; i++) begin
         div = d[i][6:0];
         run(c[i], 30000);
         check(n > bus[i] + (op[i] - 1) * (d[i] + 1), 1'b1);
         check(n <= bus[i] + op[i] * (d[i] + 1) + 2, 1'b1);
         check({busy, illeg}, 2'b00);
      end
   endtask
   task automatic t_misc();
      run(8'h05, 10);
      check(n, 1);
      check({busy, illeg}, 2'b01);
      fork
         run(8'h0d, 1000);
         begin
            repeat (100) @(negedge clk);
            code = 8'h04;
            go = 1'b1;
            @(negedge clk);
            go = 1'b0;
         end
      join
      check(n, 351);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      check({done, vfail, illeg}, 3'b000);
      run(8'h0e, 30);
      check(busy, 1'b1);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      check({busy, done}, 2'b00);
      nrst = 1'b1;
      run(8'h0d, 1000);
      check(n, 351);
   endtask
   initial begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      check({busy, done, vfail, illeg}, 4'h0);
      t_bus();
      t_blank();
      t_op();
      t_misc();
      close_out();
   end
   initial begin
      #720000;
      err_total++;
      close_out();
   end
endmodule
